/* meter_regs_pkg.sv */
// constants, layouts and carrier types for the metering register bank
//
// Notes on behaviour
// - zero-cross count resets to 100, holds 1..16777215; zero is never stored
// - full-scale pulse rate setting; 4kHz word rate gives at most 2kHz pulses
// - full-scale setting is a signed fraction, binary point left of MSB
// - three 4-bit generator sources; codes 9 to 15 are flagged unused
// - serial lock 0x16 blocks serial writes except lock and status; 0x09 lifts
// - engine lock 0x16 blocks engine writes to lockable registers; 0x09 lifts
// - phase detection starts only when the enable code 10110 is written
// - phase count tallies word-rate samples until the stopping zero crossing
// - completion bit 23 reads 1 once the count is valid, else 0
// - direction 0 stops on rising crossing, 1 on falling crossing
// - 24-bit checksum of critical registers, reset value zero
// - status bits clear on write of one; writing zero has no effect
// - low-rate ready bit 23 sets on updates, instruction done and reset
// - sample ready bit 22 sets on each word-rate result update
// - engine overrun bit 18 sets when a sample arrives before the last ends
// - power range bits 15 and 14 set on power result overflow
// - range bits 13,12 current and 11,10 voltage set on overflow
// - swell bits 17,16 and dip bits 7,6 set on detection
// - bit 5 sets on temperature refresh, bit 4 on frequency ratio refresh
// - bit 3 sets when an unknown serial command arrives
// - bit 2 sets on a serial receive checksum error
// - bit 0 sets on a serial receive timeout
// - interrupt output is any status bit whose mask bit is one; mask resets 0
package meter_regs_pkg;

  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;

  // register indices on the serial port
  localparam logic [5:0] OFF_CHECKSUM   = 6'h01;
  localparam logic [5:0] OFF_MASK       = 6'h03;
  localparam logic [5:0] OFF_PULSE_SRC  = 6'h09;
  localparam logic [5:0] OFF_STATUS     = 6'h17;
  localparam logic [5:0] OFF_PULSE_RATE = 6'h1c;
  localparam logic [5:0] OFF_LOCK       = 6'h22;
  localparam logic [5:0] OFF_PHASE      = 6'h30;
  localparam logic [5:0] OFF_ZX         = 6'h37;

  // reset values
  localparam logic [23:0] RST_ZX     = 24'h000064;
  localparam logic [23:0] RST_RATE   = 24'h800000;
  localparam logic [23:0] RST_STATUS = 24'h800000;
  localparam logic [23:0] RST_ZERO   = 24'h000000;

  // implemented-bit masks, everything else reads zero
  localparam logic [23:0] USED_SRC    = 24'h000fff;
  localparam logic [23:0] USED_LOCK   = 24'h001f1f;
  localparam logic [23:0] USED_STATUS = 24'he7fffd;

  // lock field layout and codes
  localparam int          LOCK_SER_LSB = 0;
  localparam int          LOCK_ENG_LSB = 8;
  localparam logic [4:0]  LOCK_ON      = 5'h16;
  localparam logic [4:0]  LOCK_OFF     = 5'h09;

  // phase register layout
  localparam int          PH_CODE_LSB  = 0;
  localparam int          PH_DIR_BIT   = 5;
  localparam int          PH_CNT_LSB   = 16;
  localparam int          PH_DONE_BIT  = 23;
  localparam logic [4:0]  PH_EN_CODE   = 5'h16;
  localparam logic [6:0]  PH_CNT_MAX   = 7'h7f;

  // pulse generator sources
  localparam int          NUM_GEN      = 3;
  localparam int          SRC_W        = 4;
  localparam logic [3:0]  SRC_LAST     = 4'h8;

  // rates, for reference by pulse logic outside
  localparam int          OWR_HZ       = 4000;
  localparam int          PULSE_MAX_HZ = OWR_HZ / 2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [23:0] wdata;
  } reg_req_type;

  // status events, one per bit position of the status register
  typedef struct packed {
    logic       lowrate_result_ready_flag;   // 23
    logic       sample_result_ready_flag;    // 22
    logic       watchdog_overflow_flag;      // 21
    logic [1:0] rsvd_20_19;
    logic       engine_overrun_flag;         // 18
    logic       voltage2_swell_flag;
    logic       voltage1_swell_flag;
    logic       power2_range_flag;           // 15
    logic       power1_range_flag;
    logic       current2_range_flag;
    logic       current1_range_flag;
    logic       voltage2_range_flag;         // 11
    logic       voltage1_range_flag;
    logic       current2_overcurrent_flag;
    logic       current1_overcurrent_flag;
    logic       voltage2_dip_flag;           // 7
    logic       voltage1_dip_flag;
    logic       temperature_refreshed_flag;
    logic       frequency_refreshed_flag;
    logic       invalid_command_flag;        // 3
    logic       receive_checksum_error_flag;
    logic       rsvd_1;
    logic       receive_timeout_flag;        // 0
  } status_event_type;

endpackage

/* phase_seq_counter.sv */
// phase-sequence sample counter with start, stop edge and completion
`timescale 1ns/100ps
module phase_seq_counter
  import meter_regs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       dir,
  input  wire logic       owr_tick,
  input  wire logic       zc_rise,
  input  wire logic       zc_fall,
  output logic [6:0]      count,
  output logic            done
);

  typedef enum logic {IDLE, COUNTING} ph_state_type;

  ph_state_type state_reg;
  ph_state_type state_next;
  logic [6:0]   count_reg;
  logic [6:0]   count_next;
  logic         done_reg;
  logic         done_next;

  // stopping edge follows the direction bit
  wire stop_edge = dir ? zc_fall : zc_rise;
  wire can_count = owr_tick && (count_reg != PH_CNT_MAX);

  // counter saturates instead of wrapping so a late edge stays obvious
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    done_next  = done_reg;
    case (state_reg)
      IDLE: begin
        if (start) begin
          state_next = COUNTING;
          count_next = 7'h00;
          done_next  = 1'b0;
        end
      end
      COUNTING: begin
        if (start) begin
          count_next = 7'h00;
          done_next  = 1'b0;
        end else if (stop_edge) begin
          state_next = IDLE;
          done_next  = 1'b1;
        end else if (can_count) begin
          count_next = count_reg + 7'h01;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= IDLE;
      count_reg <= 7'h00;
      done_reg  <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign count = count_reg;
  assign done  = done_reg;

  AST_START_CLEARS: assert property (@(posedge ref_clk) disable iff (srst)
    ce && start |=> !done && count == 7'h00)
    else $error("start did not clear count and completion");

  AST_STOP_SETS: assert property (@(posedge ref_clk) disable iff (srst)
    ce && state_reg == COUNTING && !start && stop_edge
      |=> done && $stable(count))
    else $error("stopping edge did not mark the count valid");

  AST_COUNT_STEP: assert property (@(posedge ref_clk) disable iff (srst)
    ce && state_reg == COUNTING && !start && !stop_edge && can_count
      |=> count == $past(count) + 7'h01)
    else $error("sample tick not counted");

  AST_EDGE_DIR: assert property (@(posedge ref_clk) disable iff (srst)
    ce && state_reg == COUNTING && !start && !dir && zc_fall && !zc_rise
      |=> !done)
    else $error("falling edge stopped a rising-edge count");

endmodule

/* meter_control_status_regs.sv */
// control and status register bank of the metering core
`timescale 1ns/100ps
module meter_control_status_regs
  import meter_regs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  reg_req_type            host_req,
  output logic [23:0]            host_rdata,
  output logic                   host_rvalid,
  output logic                   host_refused,
  input  reg_req_type            eng_req,
  output logic                   eng_refused,
  input  status_event_type       events,
  input  wire logic              instr_done,
  input  wire logic              owr_tick,
  input  wire logic              zc_rise,
  input  wire logic              zc_fall,
  output logic                   int_out,
  output logic [23:0]            zero_cross_count_setting,
  output logic signed [23:0]     pulse_full_scale_setting,
  output logic [2:0][3:0]        pulse_generator_source,
  output logic [2:0]             pulse_source_valid,
  output logic                   serial_locked,
  output logic                   engine_locked,
  output logic                   phase_detect_enabled
);

  // storage
  logic [23:0] zx_reg;
  logic [23:0] zx_next;
  logic [23:0] rate_reg;
  logic [23:0] rate_next;
  logic [11:0] src_reg;
  logic [11:0] src_next;
  logic [4:0]  ser_field_reg;
  logic [4:0]  ser_field_next;
  logic [4:0]  eng_field_reg;
  logic [4:0]  eng_field_next;
  logic        ser_lock_reg;
  logic        ser_lock_next;
  logic        eng_lock_reg;
  logic        eng_lock_next;
  logic [4:0]  ph_code_reg;
  logic [4:0]  ph_code_next;
  logic        ph_dir_reg;
  logic        ph_dir_next;
  logic [23:0] status_reg;
  logic [23:0] status_next;
  logic [23:0] mask_reg;
  logic [23:0] mask_next;
  logic [23:0] chk_reg;
  logic [23:0] chk_next;
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;
  logic        rvalid_reg;
  logic [6:0]  ph_count;
  logic        ph_done;
  logic [23:0] w1c_hold_reg;

  // host write qualification; lock and status stay writable when locked
  wire [5:0]  haddr     = host_req.addr;
  wire [23:0] hdata     = host_req.wdata;
  wire        h_exempt  = (haddr == OFF_LOCK) || (haddr == OFF_STATUS);
  wire        h_wr_ok   = host_req.wr && (!ser_lock_reg || h_exempt);
  wire        hw_zx     = h_wr_ok && (haddr == OFF_ZX);
  wire        hw_rate   = h_wr_ok && (haddr == OFF_PULSE_RATE);
  wire        hw_src    = h_wr_ok && (haddr == OFF_PULSE_SRC);
  wire        hw_lock   = h_wr_ok && (haddr == OFF_LOCK);
  wire        hw_phase  = h_wr_ok && (haddr == OFF_PHASE);
  wire        hw_status = h_wr_ok && (haddr == OFF_STATUS);
  wire        hw_mask   = h_wr_ok && (haddr == OFF_MASK);

  // engine may only touch the lockable pair, and loses to a host write
  wire [5:0]  eaddr     = eng_req.addr;
  wire [23:0] edata     = eng_req.wdata;
  wire        e_target  = (eaddr == OFF_ZX) || (eaddr == OFF_PULSE_RATE);
  wire        e_wr_ok   = eng_req.wr && !eng_lock_reg && e_target;
  wire        ew_zx     = e_wr_ok && (eaddr == OFF_ZX) && !hw_zx;
  wire        ew_rate   = e_wr_ok && (eaddr == OFF_PULSE_RATE) && !hw_rate;

  assign host_refused = host_req.wr && !h_wr_ok;
  assign eng_refused  = eng_req.wr && !e_wr_ok;

  // a zero count would stall frequency measurement, so it is never stored
  wire        h_zx_good = hdata != RST_ZERO;
  wire        e_zx_good = edata != RST_ZERO;
  assign zx_next = (hw_zx && h_zx_good) ? hdata :
                   (ew_zx && e_zx_good) ? edata : zx_reg;
  assign rate_next = hw_rate ? hdata :
                     ew_rate ? edata : rate_reg;
  assign src_next = hw_src ? hdata[11:0] : src_reg;
  assign mask_next = hw_mask ? hdata : mask_reg;

  // lock fields read back as written; the state moves only on the codes
  wire [4:0] w_ser = hdata[LOCK_SER_LSB +: 5];
  wire [4:0] w_eng = hdata[LOCK_ENG_LSB +: 5];
  assign ser_field_next = hw_lock ? w_ser : ser_field_reg;
  assign eng_field_next = hw_lock ? w_eng : eng_field_reg;
  assign ser_lock_next  = (hw_lock && w_ser == LOCK_ON)  ? 1'b1 :
                          (hw_lock && w_ser == LOCK_OFF) ? 1'b0 :
                          ser_lock_reg;
  assign eng_lock_next  = (hw_lock && w_eng == LOCK_ON)  ? 1'b1 :
                          (hw_lock && w_eng == LOCK_OFF) ? 1'b0 :
                          eng_lock_reg;

  // phase control fields and the start pulse
  wire [4:0] w_code   = hdata[PH_CODE_LSB +: 5];
  wire       ph_start = hw_phase && (w_code == PH_EN_CODE);
  assign ph_code_next = hw_phase ? w_code : ph_code_reg;
  assign ph_dir_next  = hw_phase ? hdata[PH_DIR_BIT] : ph_dir_reg;

  // sticky status: a new event beats a clear in the same cycle
  wire [23:0] ev_bits  = {events.lowrate_result_ready_flag,
                          events.sample_result_ready_flag,
                          events.watchdog_overflow_flag,
                          2'b00,
                          events.engine_overrun_flag,
                          events.voltage2_swell_flag,
                          events.voltage1_swell_flag,
                          events.power2_range_flag,
                          events.power1_range_flag,
                          events.current2_range_flag,
                          events.current1_range_flag,
                          events.voltage2_range_flag,
                          events.voltage1_range_flag,
                          events.current2_overcurrent_flag,
                          events.current1_overcurrent_flag,
                          events.voltage2_dip_flag,
                          events.voltage1_dip_flag,
                          events.temperature_refreshed_flag,
                          events.frequency_refreshed_flag,
                          events.invalid_command_flag,
                          events.receive_checksum_error_flag,
                          1'b0,
                          events.receive_timeout_flag};
  wire [23:0] set_bits = (ev_bits | {instr_done, 23'h000000})
                         & USED_STATUS;
  wire [23:0] clr_bits = hw_status ? hdata : RST_ZERO;
  assign status_next = ((status_reg & ~clr_bits) | set_bits)
                       & USED_STATUS;

  // checksum over the settings that steer metering
  assign chk_next = zx_reg + rate_reg + {12'h000, src_reg}
                    + mask_reg + {18'h00000, ph_dir_reg, ph_code_reg};

  // read mux; unmapped indices answer zero
  always_comb begin
    rdata_next = RST_ZERO;
    case (haddr)
      OFF_ZX:         rdata_next = zx_reg;
      OFF_PULSE_RATE: rdata_next = rate_reg;
      OFF_PULSE_SRC:  rdata_next = {12'h000, src_reg};
      OFF_LOCK:       rdata_next = {11'h000, eng_field_reg,
                                    3'h0, ser_field_reg};
      OFF_PHASE:      rdata_next = {ph_done, ph_count, 10'h000,
                                    ph_dir_reg, ph_code_reg};
      OFF_CHECKSUM:   rdata_next = chk_reg;
      OFF_STATUS:     rdata_next = status_reg;
      OFF_MASK:       rdata_next = mask_reg;
      default:        rdata_next = RST_ZERO;
    endcase
  end

  // settings registers; reset value of status covers the reset sequence
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      zx_reg   <= RST_ZX;
      rate_reg <= RST_RATE;
      src_reg  <= 12'h000;
      mask_reg <= RST_ZERO;
    end else if (ce) begin
      zx_reg   <= zx_next;
      rate_reg <= rate_next;
      src_reg  <= src_next;
      mask_reg <= mask_next;
    end
  end

  // lock state and lock fields
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ser_field_reg <= 5'h00;
      eng_field_reg <= 5'h00;
      ser_lock_reg  <= 1'b0;
      eng_lock_reg  <= 1'b0;
    end else if (ce) begin
      ser_field_reg <= ser_field_next;
      eng_field_reg <= eng_field_next;
      ser_lock_reg  <= ser_lock_next;
      eng_lock_reg  <= eng_lock_next;
    end
  end

  // phase fields, status, checksum
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_code_reg <= 5'h00;
      ph_dir_reg  <= 1'b0;
      status_reg  <= RST_STATUS;
      chk_reg     <= RST_ZERO;
    end else if (ce) begin
      ph_code_reg <= ph_code_next;
      ph_dir_reg  <= ph_dir_next;
      status_reg  <= status_next;
      chk_reg     <= chk_next;
    end
  end

  // bits a status write asked to clear, kept for the clear check
  always_ff @(posedge ref_clk) begin
    w1c_hold_reg <= hdata & ~set_bits & USED_STATUS;
  end

  // read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg  <= RST_ZERO;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg  <= host_req.rd ? rdata_next : rdata_reg;
      rvalid_reg <= host_req.rd;
    end
  end

  phase_seq_counter u_phase (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .ce       (ce),
    .start    (ph_start),
    .dir      (ph_dir_reg),
    .owr_tick (owr_tick),
    .zc_rise  (zc_rise),
    .zc_fall  (zc_fall),
    .count    (ph_count),
    .done     (ph_done)
  );

  // per-generator source fields; unused codes are flagged, not remapped
  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g++) begin : gen_src
      assign pulse_generator_source[g] = src_reg[g*SRC_W +: SRC_W];
      assign pulse_source_valid[g] =
        src_reg[g*SRC_W +: SRC_W] <= SRC_LAST;
    end
  endgenerate

  // outputs
  assign int_out    = |(status_reg & mask_reg);
  assign host_rdata  = rdata_reg;
  assign host_rvalid = rvalid_reg;
  assign zero_cross_count_setting = zx_reg;
  assign pulse_full_scale_setting = rate_reg;
  assign serial_locked = ser_lock_reg;
  assign engine_locked = eng_lock_reg;
  assign phase_detect_enabled = ph_code_reg == PH_EN_CODE;

  AST_HOST_LOCK: assert property (@(posedge ref_clk) disable iff (srst)
    ce && ser_lock_reg && host_req.wr && !h_exempt && !eng_req.wr
      |=> $stable(zx_reg) && $stable(src_reg) && $stable(mask_reg))
    else $error("serial write reached a locked register");

  AST_ENGINE_LOCK: assert property (@(posedge ref_clk) disable iff (srst)
    ce && eng_lock_reg && eng_req.wr && !host_req.wr
      |=> $stable(zx_reg) && $stable(rate_reg))
    else $error("engine write reached a locked register");

  AST_LOCK_CODE: assert property (@(posedge ref_clk) disable iff (srst)
    ce && host_req.wr && haddr == OFF_LOCK && w_ser == LOCK_ON
      ##1 ce && host_req.wr && haddr == OFF_ZX && !eng_req.wr
      |=> $stable(zx_reg))
    else $error("lock code did not protect the next write");

  AST_W1C: assert property (@(posedge ref_clk) disable iff (srst)
    ce && hw_status && (hdata & ~set_bits & status_reg) != RST_ZERO
      |=> (status_reg & w1c_hold_reg) == RST_ZERO)
    else $error("write of one did not clear a status bit");

  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (srst)
    ce && (instr_done || events.lowrate_result_ready_flag)
      |=> status_reg[23])
    else $error("low-rate ready event lost");

  AST_IRQ: assert property (@(posedge ref_clk) disable iff (srst)
    int_out == ((status_reg & mask_reg) != RST_ZERO))
    else $error("interrupt output disagrees with status and mask");

  AST_ZX_NONZERO: assert property (@(posedge ref_clk) disable iff (srst)
    ce && hw_zx && !h_zx_good && !eng_req.wr
      |=> $stable(zx_reg) && zx_reg != RST_ZERO)
    else $error("zero stored in the zero-cross count");

  AST_CHECKSUM: assert property (@(posedge ref_clk) disable iff (srst)
    ce |=> chk_reg == $past(chk_next))
    else $error("checksum did not follow the critical registers");

  AST_PHASE_START: assert property (@(posedge ref_clk) disable iff (srst)
    ce && hw_phase && w_code != PH_EN_CODE && !ph_done && !zc_rise
      && !zc_fall
      |=> !ph_done && phase_detect_enabled == 1'b0)
    else $error("phase detection started without the enable code");

endmodule

/* tb_meter_control_status_regs.sv */
// self-checking testbench for the metering control and status registers
`timescale 1ns/100ps
module tb_meter_control_status_regs;
  import meter_regs_pkg::*;

  logic               ref_clk;
  logic               srst;
  logic               ce;
  reg_req_type        host_req;
  reg_req_type        eng_req;
  status_event_type   events;
  logic               instr_done;
  logic               owr_tick;
  logic               zc_rise;
  logic               zc_fall;
  logic [23:0]        host_rdata;
  logic               host_rvalid;
  logic               host_refused;
  logic               eng_refused;
  logic               int_out;
  logic [23:0]        zx_set;
  logic signed [23:0] rate_set;
  logic [2:0][3:0]    src_set;
  logic [2:0]         src_valid;
  logic               ser_lk;
  logic               eng_lk;
  logic               ph_en;
  int                 num_errors;
  int                 total_checks;
  int                 flag_bits[17] = '{22, 18, 17, 16, 15, 14, 13, 12, 11,
                                        10, 7, 6, 5, 4, 3, 2, 0};

  meter_control_status_regs u_dut (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_refused(host_refused), .eng_req(eng_req),
    .eng_refused(eng_refused), .events(events), .instr_done(instr_done),
    .owr_tick(owr_tick), .zc_rise(zc_rise), .zc_fall(zc_fall),
    .int_out(int_out), .zero_cross_count_setting(zx_set),
    .pulse_full_scale_setting(rate_set), .pulse_generator_source(src_set),
    .pulse_source_valid(src_valid), .serial_locked(ser_lk),
    .engine_locked(eng_lk), .phase_detect_enabled(ph_en));

  // free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // every task starts and ends on a falling edge; idle cycle between calls
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] d,
                        input logic exp_ref);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    #1;
    chk1(host_refused, exp_ref);
    @(negedge ref_clk);
    host_req = '0;
    @(negedge ref_clk);
  endtask

  task automatic rd_reg(input logic [5:0] a, input logic [23:0] exp);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
    @(negedge ref_clk);
    host_req = '0;
    chk1(host_rvalid, 1'b1);
    chk24(host_rdata, exp);
    @(negedge ref_clk);
  endtask

  task automatic eng_wr(input logic [5:0] a, input logic [23:0] d,
                        input logic exp_ref);
    eng_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    #1;
    chk1(eng_refused, exp_ref);
    @(negedge ref_clk);
    eng_req = '0;
    @(negedge ref_clk);
  endtask

  // one-cycle pulse on owr_tick (0), zc_rise (1) or zc_fall (2)
  task automatic pin(input int k);
    {owr_tick, zc_rise, zc_fall} = 3'h4 >> k;
    @(negedge ref_clk);
    {owr_tick, zc_rise, zc_fall} = 3'h0;
    @(negedge ref_clk);
  endtask

  task automatic ev(input logic [23:0] v);
    events = status_event_type'(v);
    @(negedge ref_clk);
    events = status_event_type'(24'h000000);
    @(negedge ref_clk);
  endtask

  // watchdog: the full sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test;
  end

  initial begin
    logic [23:0] b;
    num_errors = 0;
    total_checks = 0;
    {srst, ce, instr_done, owr_tick, zc_rise, zc_fall} = 6'h30;
    host_req = '0;
    eng_req = '0;
    events = status_event_type'(24'h000000);
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    // reset values and read-only or unmapped places
    chk1(int_out, 1'b0);
    rd_reg(OFF_ZX, 24'h000064);
    rd_reg(OFF_PULSE_RATE, 24'h800000);
    rd_reg(OFF_PULSE_SRC, 24'h000000);
    rd_reg(OFF_LOCK, 24'h000000);
    rd_reg(OFF_PHASE, 24'h000000);
    rd_reg(OFF_MASK, 24'h000000);
    rd_reg(OFF_STATUS, 24'h800000);
    rd_reg(OFF_CHECKSUM, 24'h800064);
    wr_reg(OFF_CHECKSUM, 24'h000001, 1'b0);
    rd_reg(OFF_CHECKSUM, 24'h800064);
    rd_reg(6'h3f, 24'h000000);
    // count at 7fffff, then a zero write that must be dropped
    wr_reg(OFF_ZX, 24'h7fffff, 1'b0);
    chk24(zx_set, 24'h7fffff);
    wr_reg(OFF_ZX, 24'h000000, 1'b0);
    rd_reg(OFF_ZX, 24'h7fffff);
    wr_reg(OFF_PULSE_RATE, 24'h400000, 1'b0);
    chk24(rate_set, 24'h400000);
    // every source code on each generator, reserved bits written high
    for (int c = 0; c < 16; c++) begin
      b = {12'h000, 4'(c), 4'(15 - c), 4'(c)};
      wr_reg(OFF_PULSE_SRC, b | 24'hfff000, 1'b0);
      rd_reg(OFF_PULSE_SRC, b);
      chk24({12'h000, src_set}, b);
      chk24({21'h0, src_valid}, {21'h0, c < 9, 15 - c < 9, c < 9});
    end
    wr_reg(OFF_MASK, 24'h000008, 1'b0);
    // serial lock: locked writes refused, status still writable
    wr_reg(OFF_LOCK, 24'h000016, 1'b0);
    chk1(ser_lk, 1'b1);
    wr_reg(OFF_ZX, 24'h000005, 1'b1);
    wr_reg(OFF_MASK, 24'hffffff, 1'b1);
    rd_reg(OFF_ZX, 24'h7fffff);
    wr_reg(OFF_STATUS, 24'h800000, 1'b0);
    rd_reg(OFF_STATUS, 24'h000000);
    wr_reg(OFF_LOCK, 24'h000009, 1'b0);
    chk1(ser_lk, 1'b0);
    // engine port before and after its lock
    eng_wr(OFF_ZX, 24'h000009, 1'b0);
    chk24(zx_set, 24'h000009);
    wr_reg(OFF_LOCK, 24'h001600, 1'b0);
    chk1(eng_lk, 1'b1);
    eng_wr(OFF_PULSE_RATE, 24'h123456, 1'b1);
    chk24(rate_set, 24'h400000);
    wr_reg(OFF_LOCK, 24'h000900, 1'b0);
    chk1(eng_lk, 1'b0);
    rd_reg(OFF_LOCK, 24'h000900);
    // each status flag but 23, 21, 9 and 8: set, survive a zero write, clear on a one
    foreach (flag_bits[i]) begin
      b = 24'h000001 << flag_bits[i];
      ev(b);
      chk1(int_out, flag_bits[i] == 3);
      rd_reg(OFF_STATUS, b);
      wr_reg(OFF_STATUS, ~b, 1'b0);
      rd_reg(OFF_STATUS, b);
      wr_reg(OFF_STATUS, b, 1'b0);
      rd_reg(OFF_STATUS, 24'h000000);
    end
    chk1(int_out, 1'b0);
    instr_done = 1'b1;
    @(negedge ref_clk);
    instr_done = 1'b0;
    @(negedge ref_clk);
    rd_reg(OFF_STATUS, 24'h800000);
    // phase count stopped by a rising crossing, a falling one ignored
    wr_reg(OFF_PHASE, 24'h000016, 1'b0);
    chk1(ph_en, 1'b1);
    repeat (3) pin(0);
    pin(2);
    rd_reg(OFF_PHASE, 24'h030016);
    pin(1);
    rd_reg(OFF_PHASE, 24'h830016);
    // restart with the falling edge selected
    wr_reg(OFF_PHASE, 24'h000036, 1'b0);
    rd_reg(OFF_PHASE, 24'h000036);
    repeat (2) pin(0);
    pin(1);
    pin(2);
    rd_reg(OFF_PHASE, 24'h820036);
    wr_reg(OFF_PHASE, 24'h000035, 1'b0);
    chk1(ph_en, 1'b0);
    rd_reg(OFF_CHECKSUM, 24'h000009 + 24'h400000 + 24'h000f0f
                         + 24'h000008 + 24'h000035);
    end_of_test;
  end
endmodule
